//--- pkg/aios_pkg.sv
// shared constants, register map and state types for analog io allocation and scaling
package aios_pkg;
    localparam int DW = 16;
    localparam int ADC_W = 12;
    // analog function selector codes
    localparam logic [2:0] FN_UNUSED = 3'h0;
    localparam logic [2:0] FN_EXTREF = 3'h1;
    localparam logic [2:0] FN_FEEDBACK = 3'h2;
    localparam logic [2:0] FN_AUX = 3'h3;
    localparam logic [2:0] FN_SP1 = 3'h4;
    localparam logic [2:0] FN_SP3 = 3'h6;
    // scaling and display format codes
    localparam logic [1:0] FMT_FOLLOWER = 2'h2;
    localparam logic [1:0] FMT_OFFSET = 2'h3;
    // forced values while the analog input stands in for a frequency, then converter, source, ratio and output scale constants
    localparam logic [15:0] RPM_FORCED = 16'h0fff;
    localparam logic [15:0] PPR_FORCED = 16'h003c;
    localparam logic [11:0] ADC_FULL = 12'h0fff;
    localparam logic [7:0] SRC_TACH = 8'h28;
    localparam logic [15:0] RATIO_ONE = 16'h03e8;
    localparam logic signed [31:0] AOUT_MAX = 32'sh0000_7fff;
    // output damping: first order step every tick, corner near 1 Hz
    localparam int CLK_PERIOD_NS = 4;
    localparam int FILT_TICK_NS = 1000000;
    localparam int FILT_TICK_CYC = FILT_TICK_NS / CLK_PERIOD_NS;
    localparam int FILT_SHIFT = 7;
    // register byte offsets
    localparam logic [7:0] OFS_FN_SEL = 8'h00;
    localparam logic [7:0] OFS_SEC_SCALE = 8'h04;
    localparam logic [7:0] OFS_SEC_DISP = 8'h08;
    localparam logic [7:0] OFS_EXT_RPM = 8'h0c;
    localparam logic [7:0] OFS_FB_RPM = 8'h10;
    localparam logic [7:0] OFS_AUX_RPM = 8'h14;
    localparam logic [7:0] OFS_PPR_EXT = 8'h18;
    localparam logic [7:0] OFS_PPR_FB = 8'h1c;
    localparam logic [7:0] OFS_PPR_AUX = 8'h20;
    localparam logic [7:0] OFS_PRI_EU = 8'h24;
    localparam logic [7:0] OFS_SEC_EU = 8'h28;
    localparam logic [7:0] OFS_PRI_PLUS = 8'h2c;
    localparam logic [7:0] OFS_PRI_MINUS = 8'h30;
    localparam logic [7:0] OFS_SEC_PLUS = 8'h34;
    localparam logic [7:0] OFS_SEC_MINUS = 8'h38;
    localparam logic [7:0] OFS_AOUT_SRC = 8'h3c;
    localparam logic [7:0] OFS_AOUT_FULL = 8'h40;
    localparam logic [7:0] OFS_FIRST_SP = 8'h44;
    localparam logic [7:0] OFS_ADC = 8'h48;
    localparam logic [7:0] OFS_STATUS = 8'h4c;
    localparam logic [7:0] OFS_SPEED = 8'h50;

    typedef enum logic [1:0] {
        BP_IDLE = 2'b00,
        BP_WRITE = 2'b01,
        BP_READ = 2'b11
    } aios_phase_t;

    typedef struct packed {
        aios_phase_t phase;
        logic [7:0] addr;
        logic ready;
        logic resp;
        logic [31:0] rdata;
        logic [2:0] fnSel;
        logic [1:0] secScaleFmt;
        logic [1:0] secDispFmt;
        logic [15:0] extRpmMax;
        logic [15:0] fbRpmMax;
        logic [15:0] auxRpmMax;
        logic [15:0] pprExt;
        logic [15:0] pprFb;
        logic [15:0] pprAux;
        logic [15:0] priSetEu;
        logic [15:0] secSetEu;
        logic [15:0] priPlus;
        logic [15:0] priMinus;
        logic [15:0] secPlus;
        logic [15:0] secMinus;
        logic [7:0] aoutSrc;
        logic [15:0] aoutFull;
        logic [15:0] firstSp;
        logic [11:0] adcCode;
        logic [15:0] extRefOut;
        logic [15:0] fbOut;
        logic [15:0] auxOut;
        logic [15:0] anaSetpoint;
        logic [3:0] spReplace;
        logic followerFmt;
        logic offsetFmt;
        logic followerDisp;
        logic signed [31:0] motorSpeed;
    } aios_state_t;

    typedef struct packed {
        logic [31:0] tickCnt;
        logic signed [47:0] acc;
        logic signed [15:0] level;
    } aios_filt_t;
endpackage

//--- hw/aios_aout.sv
// analog output scaling against full scale, signed, with slow damping
`timescale 1ns/1ps
module aios_aout import aios_pkg::*; #(
    parameter int TICK_CYC = FILT_TICK_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic signed [31:0] value,
    input wire logic [15:0] fullScale,
    output logic signed [15:0] level
);
    if (TICK_CYC < 1) begin : g_bad_tick
        $error("aios_aout: TICK_CYC must be at least one");
    end

    aios_filt_t s;
    aios_filt_t next_s;
    logic signed [47:0] scaled;
    logic signed [47:0] target;

    always_comb begin
        next_s = s;
        scaled = '0;
        // zero full scale would divide by zero: output parks at zero
        if (fullScale != '0) begin
            scaled = (48'(value) * 48'(AOUT_MAX)) / $signed({32'h0000_0000, fullScale});
        end
        target = scaled;
        if (scaled > 48'(AOUT_MAX)) begin
            target = 48'(AOUT_MAX);
        end else if (scaled < -48'(AOUT_MAX)) begin
            target = -48'(AOUT_MAX);
        end
        if (s.tickCnt >= 32'(TICK_CYC - 1)) begin
            next_s.tickCnt = '0;
            // too slow for cascade loops: the corner is about one hertz
            next_s.acc = s.acc + (target - (s.acc >>> FILT_SHIFT));
        end else begin
            next_s.tickCnt = s.tickCnt + 32'h0000_0001;
        end
        next_s.level = 16'(next_s.acc >>> FILT_SHIFT);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign level = s.level;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_neg_sign: assert property (ce && value < 0 && fullScale != '0 |-> target <= 0)
        else $error("negative value gave positive target");
    a_tick_spacing: assert property (s.tickCnt <= 32'(TICK_CYC - 1))
        else $error("filter tick counter overran");
    c_neg_out: cover property (s.level < 0);
endmodule // aios_aout

//--- hw/aios_top.sv
// analog input allocation, parameter forcing, offset exclusion and analog output
`timescale 1ns/1ps
// Overview of operation
// - selector 1: analog input replaces the external reference frequency
// - selector 3: analog input replaces aux frequency; set selector first
// - selector 4: analog input supplies the first setpoint
// - frequency replacement forces max rpm 4095, ppr 60, writes rejected
// - converter code 4095 stands for 10 volts, linear to zero
// - writing a plus or minus offset clears its partner
// - analog setpoint is level times engineering units over full scale
// - reading first setpoint returns the analog setpoint while replaced
// - output source code picks the monitored item, 40 is tach
// - full scale value maps to maximum output, proportional below
// - negative selected values give negative output
// - analog output is damped to about one hertz
// - offset format speed from ratio, reference, aux and offset
// - secondary scaling 2 is follower, 3 is offset format
// - secondary display 2 selects follower display scaling
// - selector 0 unused, 2 feedback, 5 to 7 setpoints two to four
module aios_top import aios_pkg::*; #(
    parameter int TICK_CYC = FILT_TICK_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [11:0] adcCode,
    input wire logic adcValid,
    input wire logic [15:0] extRefFreq,
    input wire logic [15:0] fbFreq,
    input wire logic [15:0] auxFreq,
    input wire logic signed [31:0] monData,
    output logic [7:0] monCode,
    output logic [15:0] extRefSel,
    output logic [15:0] fbSel,
    output logic [15:0] auxSel,
    output logic [15:0] anaSetpoint,
    output logic [3:0] spReplace,
    output logic followerFmt,
    output logic offsetFmt,
    output logic followerDisp,
    output logic signed [31:0] motorSpeed,
    output logic signed [15:0] aoutLevel
);
    if (TICK_CYC < 1) begin : g_bad_tick
        $error("aios_top: TICK_CYC must be at least one");
    end

    aios_state_t s;
    aios_state_t next_s;
    logic [27:0] spProd;
    logic [15:0] spEu;
    logic [31:0] ratioProd;
    logic takeAddr;

    function automatic logic [31:0] readReg(input aios_state_t st, input logic [7:0] a);
        logic [31:0] r;
        r = '0;
        if (a == OFS_FN_SEL) begin
            r = 32'(st.fnSel);
        end else if (a == OFS_SEC_SCALE) begin
            r = 32'(st.secScaleFmt);
        end else if (a == OFS_SEC_DISP) begin
            r = 32'(st.secDispFmt);
        end else if (a == OFS_EXT_RPM) begin
            r = 32'(st.extRpmMax);
        end else if (a == OFS_FB_RPM) begin
            r = 32'(st.fbRpmMax);
        end else if (a == OFS_AUX_RPM) begin
            r = 32'(st.auxRpmMax);
        end else if (a == OFS_PPR_EXT) begin
            r = 32'(st.pprExt);
        end else if (a == OFS_PPR_FB) begin
            r = 32'(st.pprFb);
        end else if (a == OFS_PPR_AUX) begin
            r = 32'(st.pprAux);
        end else if (a == OFS_PRI_EU) begin
            r = 32'(st.priSetEu);
        end else if (a == OFS_SEC_EU) begin
            r = 32'(st.secSetEu);
        end else if (a == OFS_PRI_PLUS) begin
            r = 32'(st.priPlus);
        end else if (a == OFS_PRI_MINUS) begin
            r = 32'(st.priMinus);
        end else if (a == OFS_SEC_PLUS) begin
            r = 32'(st.secPlus);
        end else if (a == OFS_SEC_MINUS) begin
            r = 32'(st.secMinus);
        end else if (a == OFS_AOUT_SRC) begin
            r = 32'(st.aoutSrc);
        end else if (a == OFS_AOUT_FULL) begin
            r = 32'(st.aoutFull);
        end else if (a == OFS_FIRST_SP) begin
            r = st.spReplace[0] ? 32'(st.anaSetpoint) : 32'(st.firstSp);
        end else if (a == OFS_ADC) begin
            r = 32'(st.adcCode);
        end else if (a == OFS_STATUS) begin
            r = {25'h000_0000, st.spReplace, st.followerDisp, st.offsetFmt, st.followerFmt};
        end else if (a == OFS_SPEED) begin
            r = st.motorSpeed;
        end
        return r;
    endfunction

    assign takeAddr = hsel && htrans[1] && hready;

    always_comb begin
        next_s = s;
        next_s.phase = BP_IDLE;
        next_s.ready = 1'b1;
        next_s.resp = 1'b0;
        if (adcValid) begin
            next_s.adcCode = adcCode;
        end
        if (s.phase == BP_WRITE) begin
            if (s.addr == OFS_FN_SEL) begin
                next_s.fnSel = hwdata[2:0];
            end else if (s.addr == OFS_SEC_SCALE) begin
                next_s.secScaleFmt = hwdata[1:0];
            end else if (s.addr == OFS_SEC_DISP) begin
                next_s.secDispFmt = hwdata[1:0];
            end else if (s.addr == OFS_EXT_RPM) begin
                next_s.extRpmMax = hwdata[15:0];
            end else if (s.addr == OFS_FB_RPM) begin
                next_s.fbRpmMax = hwdata[15:0];
            end else if (s.addr == OFS_AUX_RPM) begin
                next_s.auxRpmMax = hwdata[15:0];
            end else if (s.addr == OFS_PPR_EXT) begin
                next_s.pprExt = hwdata[15:0];
            end else if (s.addr == OFS_PPR_FB) begin
                next_s.pprFb = hwdata[15:0];
            end else if (s.addr == OFS_PPR_AUX) begin
                next_s.pprAux = hwdata[15:0];
            end else if (s.addr == OFS_PRI_EU) begin
                next_s.priSetEu = hwdata[15:0];
            end else if (s.addr == OFS_SEC_EU) begin
                next_s.secSetEu = hwdata[15:0];
            end else if (s.addr == OFS_PRI_PLUS) begin
                next_s.priPlus = hwdata[15:0];
                next_s.priMinus = '0;
            end else if (s.addr == OFS_PRI_MINUS) begin
                next_s.priMinus = hwdata[15:0];
                next_s.priPlus = '0;
            end else if (s.addr == OFS_SEC_PLUS) begin
                next_s.secPlus = hwdata[15:0];
                next_s.secMinus = '0;
            end else if (s.addr == OFS_SEC_MINUS) begin
                next_s.secMinus = hwdata[15:0];
                next_s.secPlus = '0;
            end else if (s.addr == OFS_AOUT_SRC) begin
                next_s.aoutSrc = hwdata[7:0];
            end else if (s.addr == OFS_AOUT_FULL) begin
                next_s.aoutFull = hwdata[15:0];
            end else if (s.addr == OFS_FIRST_SP) begin
                next_s.firstSp = hwdata[15:0];
            end
        end
        // forcing every cycle makes any later write to these fields a no-op
        if (next_s.fnSel == FN_EXTREF) begin
            next_s.extRpmMax = RPM_FORCED;
            next_s.pprExt = PPR_FORCED;
        end
        if (next_s.fnSel == FN_FEEDBACK) begin
            next_s.fbRpmMax = RPM_FORCED;
            next_s.pprFb = PPR_FORCED;
        end
        if (next_s.fnSel == FN_AUX) begin
            next_s.auxRpmMax = RPM_FORCED;
            next_s.pprAux = PPR_FORCED;
        end
        next_s.extRefOut = (next_s.fnSel == FN_EXTREF) ? DW'(next_s.adcCode) : extRefFreq;
        next_s.fbOut = (next_s.fnSel == FN_FEEDBACK) ? DW'(next_s.adcCode) : fbFreq;
        next_s.auxOut = (next_s.fnSel == FN_AUX) ? DW'(next_s.adcCode) : auxFreq;
        for (int i = 0; i < 4; i++) begin
            next_s.spReplace[i] = (next_s.fnSel == 3'(FN_SP1 + 3'(i)));
        end
        // setpoints one and two use primary units, three and four secondary
        spEu = (next_s.fnSel >= FN_SP3) ? next_s.secSetEu : next_s.priSetEu;
        spProd = 28'(next_s.adcCode) * 28'(spEu);
        next_s.anaSetpoint = 16'(spProd / 28'(ADC_FULL));
        next_s.followerFmt = (next_s.secScaleFmt == FMT_FOLLOWER);
        next_s.offsetFmt = (next_s.secScaleFmt == FMT_OFFSET);
        next_s.followerDisp = (next_s.secDispFmt == FMT_FOLLOWER);
        ratioProd = (32'(next_s.extRefOut) * 32'(next_s.secSetEu)) / 32'(RATIO_ONE);
        next_s.motorSpeed = '0;
        if (next_s.offsetFmt) begin
            next_s.motorSpeed = $signed(ratioProd) + $signed(32'(next_s.auxOut))
                + $signed(32'(next_s.secPlus)) - $signed(32'(next_s.secMinus));
        end
        if (takeAddr) begin
            next_s.addr = haddr[7:0];
            next_s.phase = hwrite ? BP_WRITE : BP_READ;
            if (!hwrite) begin
                next_s.rdata = readReg(s, haddr[7:0]);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= '0;
            s.ready <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    aios_aout #(
        .TICK_CYC(TICK_CYC)
    ) u_aout (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .value(monData),
        .fullScale(s.aoutFull),
        .level(aoutLevel)
    );

    assign hreadyout = s.ready;
    assign hresp = s.resp;
    assign hrdata = s.rdata;
    assign monCode = s.aoutSrc;
    assign extRefSel = s.extRefOut;
    assign fbSel = s.fbOut;
    assign auxSel = s.auxOut;
    assign anaSetpoint = s.anaSetpoint;
    assign spReplace = s.spReplace;
    assign followerFmt = s.followerFmt;
    assign offsetFmt = s.offsetFmt;
    assign followerDisp = s.followerDisp;
    assign motorSpeed = s.motorSpeed;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_extref_sub: assert property (s.fnSel == FN_EXTREF |-> s.extRefOut == DW'(s.adcCode))
        else $error("external reference not replaced");
    a_aux_sub: assert property (s.fnSel == FN_AUX |-> s.auxOut == DW'(s.adcCode))
        else $error("aux frequency not replaced");
    a_fb_sub: assert property ($past(ce) && !$past(rst) && s.fnSel != FN_FEEDBACK
        |-> s.fbOut == $past(fbFreq))
        else $error("feedback replaced while not selected");
    a_sp_flag: assert property (s.spReplace[0] == (s.fnSel == FN_SP1))
        else $error("first setpoint flag wrong");
    a_force_hold: assert property (s.fnSel == FN_EXTREF && ce ##1 s.fnSel == FN_EXTREF
        |-> s.extRpmMax == RPM_FORCED && s.pprExt == PPR_FORCED)
        else $error("forced reference scaling altered");
    a_sp_scale: assert property (s.spReplace[0] && s.adcCode == ADC_FULL |-> s.anaSetpoint == s.priSetEu)
        else $error("full scale setpoint mismatch");
    a_offset_excl: assert property (s.priPlus == '0 || s.priMinus == '0)
        else $error("both primary offsets nonzero");
    a_sec_excl: assert property (s.secPlus == '0 || s.secMinus == '0)
        else $error("both secondary offsets nonzero");
    a_sp_read: assert property (ce && takeAddr && !hwrite && haddr[7:0] == OFS_FIRST_SP && s.spReplace[0]
        |=> s.rdata == 32'($past(s.anaSetpoint)))
        else $error("first setpoint read ignored analog value");
    a_speed_off: assert property (!s.offsetFmt |-> s.motorSpeed == 0)
        else $error("speed driven outside offset format");
    a_fmt_decode: assert property (ce && hsel && htrans[1] && hready && hwrite && haddr[7:0] == OFS_SEC_SCALE
        ##1 ce && hwdata[1:0] == FMT_OFFSET |=> s.offsetFmt && !s.followerFmt)
        else $error("offset format not decoded");
    a_ext_pass: assert property ($past(ce) && !$past(rst) && s.fnSel != FN_EXTREF
        |-> s.extRefOut == $past(extRefFreq))
        else $error("reference replaced while not selected");
    a_fb_repl: assert property (s.fnSel == FN_FEEDBACK |-> s.fbOut == DW'(s.adcCode))
        else $error("feedback not replaced");
    a_fb_force: assert property (s.fnSel == FN_FEEDBACK
        |-> s.fbRpmMax == RPM_FORCED && s.pprFb == PPR_FORCED)
        else $error("feedback scaling not forced");
    a_aux_force: assert property (s.fnSel == FN_AUX
        |-> s.auxRpmMax == RPM_FORCED && s.pprAux == PPR_FORCED)
        else $error("aux scaling not forced");
    a_sp_onehot: assert property ($onehot0(s.spReplace))
        else $error("several setpoints replaced");
    a_pri_clear: assert property (ce && s.phase == BP_WRITE && s.addr == OFS_PRI_PLUS
        |=> s.priMinus == '0)
        else $error("plus write kept minus offset");
    a_src_write: assert property (ce && s.phase == BP_WRITE && s.addr == OFS_AOUT_SRC
        |=> monCode == $past(hwdata[7:0]))
        else $error("source select write lost");
    a_full_write: assert property (ce && s.phase == BP_WRITE && s.addr == OFS_AOUT_FULL
        |=> s.aoutFull == $past(hwdata[15:0]))
        else $error("full scale write lost");
    a_adc_sample: assert property (ce && adcValid |=> s.adcCode == $past(adcCode))
        else $error("converter code not sampled");

    c_extref: cover property (s.fnSel == FN_EXTREF && s.extRefOut == DW'(ADC_FULL));
    c_sp_read: cover property (s.phase == BP_READ && s.addr == OFS_FIRST_SP && s.spReplace[0]);
    c_offset_run: cover property (s.offsetFmt && s.motorSpeed != 0);
    c_tach_src: cover property (s.aoutSrc == SRC_TACH);
endmodule // aios_top

//--- dv/aios_far_model.sv
// far side model: converter, frequency sensors and the monitor selector
`timescale 1ns/1ps
module aios_far_model import aios_pkg::*; (
    input wire logic [11:0] level,
    input wire logic [15:0] extFreq,
    input wire logic signed [31:0] tachVal,
    input wire logic [7:0] monCode,
    output logic [11:0] adcCode,
    output logic adcValid,
    output logic [15:0] extRefFreq,
    output logic [15:0] fbFreq,
    output logic [15:0] auxFreq,
    output logic signed [31:0] monData
);
    // level is already the converter code, 4095 standing for full scale
    assign adcCode = level;
    // converter answers every cycle, so the freshest code is always offered
    assign adcValid = 1'b1;
    assign extRefFreq = extFreq;
    assign fbFreq = 16'h0123;
    assign auxFreq = 16'h0456;
    // other codes show a decoy so a wrong pick cannot pass for the tach
    assign monData = (monCode == SRC_TACH) ? tachVal : 32'sh0000_1111;
endmodule // aios_far_model

//--- dv/tb.sv
// self-checking bench for analog io allocation and scaling
`timescale 1ns/1ps
module tb import aios_pkg::*;;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} aios_row_t;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [11:0] level = 12'h000;
    logic [15:0] extFreq = 16'h0000;
    logic signed [31:0] tachVal = 32'sh0000_0000;
    logic hreadyout, hresp, adcValid, followerFmt, offsetFmt, followerDisp;
    logic [31:0] hrdata;
    logic [11:0] adcCode;
    logic [7:0] monCode;
    logic [15:0] extRefFreq, fbFreq, auxFreq, extRefSel, fbSel, auxSel, anaSetpoint;
    logic [3:0] spReplace;
    logic signed [31:0] monData, motorSpeed;
    logic signed [15:0] aoutLevel;
    logic [15:0] got;
    logic [7:0] rpmA [3] = '{OFS_EXT_RPM, OFS_FB_RPM, OFS_AUX_RPM};
    logic [7:0] pprA [3] = '{OFS_PPR_EXT, OFS_PPR_FB, OFS_PPR_AUX};
    int errTotal = 0;
    int nTests = 0;
    int cyc = 0;
    aios_row_t rows [15] = '{
        '{OFS_FN_SEL, 32'h0000_0000, 32'h0000_0000},
        '{OFS_SEC_SCALE, 32'h0000_0001, 32'h0000_0001},
        '{OFS_SEC_DISP, 32'h0000_0001, 32'h0000_0001},
        '{OFS_EXT_RPM, 32'h0000_0708, 32'h0000_0708},
        '{OFS_FB_RPM, 32'h0000_0708, 32'h0000_0708},
        '{OFS_AUX_RPM, 32'h0000_1234, 32'h0000_1234},
        '{OFS_PPR_EXT, 32'h0000_001e, 32'h0000_001e},
        '{OFS_PPR_FB, 32'h0000_003c, 32'h0000_003c},
        '{OFS_PPR_AUX, 32'h0000_0258, 32'h0000_0258},
        '{OFS_PRI_EU, 32'h0000_03e8, 32'h0000_03e8},
        '{OFS_SEC_EU, 32'h0000_07d0, 32'h0000_07d0},
        '{OFS_AOUT_SRC, 32'h0000_0028, 32'h0000_0028},
        '{OFS_AOUT_FULL, 32'h0000_07d0, 32'h0000_07d0},
        '{OFS_FIRST_SP, 32'h0000_0055, 32'h0000_0055},
        '{8'h60, 32'h0000_ffff, 32'h0000_0000}
    };

    always #2 mclk = ~mclk;

    aios_top #(.TICK_CYC(4)) u_dut (.mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .adcCode(adcCode), .adcValid(adcValid), .extRefFreq(extRefFreq), .fbFreq(fbFreq),
        .auxFreq(auxFreq), .monData(monData), .monCode(monCode), .extRefSel(extRefSel),
        .fbSel(fbSel), .auxSel(auxSel), .anaSetpoint(anaSetpoint), .spReplace(spReplace),
        .followerFmt(followerFmt), .offsetFmt(offsetFmt), .followerDisp(followerDisp),
        .motorSpeed(motorSpeed), .aoutLevel(aoutLevel));

    aios_far_model u_far (.level(level), .extFreq(extFreq), .tachVal(tachVal),
        .monCode(monCode), .adcCode(adcCode), .adcValid(adcValid), .extRefFreq(extRefFreq),
        .fbFreq(fbFreq), .auxFreq(auxFreq), .monData(monData));

    task automatic finalReport();
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
        nTests++;
        if (act !== exp) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", nm, exp, act);
        end
    endtask

    // the damped output settles only to within a count or two of its target
    task automatic chkNear(input string nm, input int exp, input logic signed [15:0] act);
        nTests++;
        if (((act >= exp - 2) && (act <= exp + 2)) !== 1'b1) begin
            errTotal++;
            $display("BAD %s expected %0d seen %0d", nm, exp, act);
        end
    endtask

    task automatic waitReady();
        @(posedge mclk);
        while (hreadyout !== 1'b1) begin
            @(posedge mclk);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? wd : 32'h0000_0000;
        waitReady();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk(nm, e, x);
    endtask

    // registered outputs load on the same edge as the register write; inputs changed after it take one cycle
    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errTotal++;
            finalReport();
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("hreadyout", 32'h0000_0001, {31'h0, hreadyout});
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdchk($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].e);
        end
        level <= 12'h0abc;
        for (int i = 0; i < 3; i++) begin
            wr(OFS_FN_SEL, i + 1);
            wr(pprA[i], 32'h0000_0005);
            wr(rpmA[i], 32'h0000_0007);
            rdchk("rpm forced", rpmA[i], {16'h0000, RPM_FORCED});
            rdchk("ppr forced", pprA[i], {16'h0000, PPR_FORCED});
            settle();
            got = (i == 0) ? extRefSel : (i == 1) ? fbSel : auxSel;
            chk("substituted", 32'h0000_0abc, {16'h0000, got});
            chk("ext untouched", i == 0 ? 32'h0000_0abc : 32'h0000_0000,
                {16'h0000, extRefSel});
        end
        level <= 12'h800;
        for (int s = 4; s < 8; s++) begin
            wr(OFS_FN_SEL, s);
            settle();
            chk("spReplace", 32'h1 << (s - 4), {28'h0, spReplace});
            chk("anaSetpoint", s < 6 ? 2048 * 1000 / 4095 : 2048 * 2000 / 4095,
                {16'h0000, anaSetpoint});
            rdchk("first sp", OFS_FIRST_SP, s == 4 ? 500 : 32'h0000_0055);
        end
        wr(OFS_FN_SEL, 32'h0000_0004);
        level <= 12'hfff;
        settle();
        chk("full scale sp", 32'h0000_03e8, {16'h0000, anaSetpoint});
        wr(OFS_PRI_PLUS, 32'h0000_005a);
        wr(OFS_PRI_MINUS, 32'h0000_0005);
        rdchk("pri plus", OFS_PRI_PLUS, 32'h0000_0000);
        rdchk("pri minus", OFS_PRI_MINUS, 32'h0000_0005);
        wr(OFS_PRI_PLUS, 32'h0000_0007);
        rdchk("pri minus", OFS_PRI_MINUS, 32'h0000_0000);
        wr(OFS_SEC_PLUS, 32'h0000_0003);
        // neutralising offset for a centred pot: 2048*1800*60/(4095*600) = 90
        wr(OFS_SEC_MINUS, 32'h0000_005a);
        rdchk("sec plus", OFS_SEC_PLUS, 32'h0000_0000);
        for (int v = 0; v < 4; v++) begin
            wr(OFS_SEC_SCALE, v);
            wr(OFS_SEC_DISP, v);
            settle();
            chk("formats", {29'h0, v == 2, v == 3, v == 2},
                {29'h0, followerFmt, offsetFmt, followerDisp});
        end
        wr(OFS_FN_SEL, 32'h0000_0003);
        wr(OFS_SEC_EU, 32'h0000_03e8);
        level <= 12'h800;
        extFreq <= 16'h0708;
        settle();
        chk("speed", 1800 + 2048 - 90, motorSpeed);
        rdchk("speed reg", OFS_SPEED, 1800 + 2048 - 90);
        ce <= 1'b0;
        extFreq <= 16'h0100;
        settle();
        chk("ce freeze", 32'h0000_0708, {16'h0000, extRefSel});
        ce <= 1'b1;
        settle();
        chk("ce run", 32'h0000_0100, {16'h0000, extRefSel});
        tachVal <= 32'sd1000;
        settle();
        chk("monCode", {24'h0, SRC_TACH}, {24'h0, monCode});
        repeat (40) @(posedge mclk);
        chk("damped", 32'h1, {31'h0, aoutLevel > 0 && aoutLevel < 16'sd4000});
        repeat (6000) @(posedge mclk);
        chkNear("aout half", 16383, aoutLevel);
        tachVal <= -32'sd1000;
        repeat (6000) @(posedge mclk);
        chkNear("aout negative", -16383, aoutLevel);
        tachVal <= 32'sd2000;
        repeat (6000) @(posedge mclk);
        chkNear("aout full", 32767, aoutLevel);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("hrdata reset", 32'h0000_0000, hrdata);
        chk("aout reset", 32'h0000_0000, {16'h0000, aoutLevel});
        rdchk("sel reset", OFS_FN_SEL, 32'h0000_0000);
        rdchk("rpm reset", OFS_EXT_RPM, 32'h0000_0000);
        finalReport();
    end
endmodule // tb
